// ---- hw/fcsm_defines.vh ----
// Command codes, pin-timing counts and identifier addresses of the flash host controller
// Contract
// RQ1: Supply low: command register stays read-only
// RQ2: Supply low: reads allowed, no writes
// RQ3: Host writes command byte to select operation
// RQ4: Writing 00H returns device to array read
// RQ5: 90H then addresses 0 and 1 give identifiers
// RQ6: High-voltage id line selects identifier by bit
// RQ7: First 30H write only stages chip erase
// RQ8: Second 30H write starts chip erase
// RQ9: Chip erase preprograms then erases, self-timed
// RQ10: Erase stops itself, no verify command needed
// RQ11: Chip erase done: poll one, toggle steady
// RQ12: 20H write only stages block erase
// RQ13: Host confirms block erase with D0H
// RQ14: Block address captured on second write fall
// RQ15: Next block load within 30us or erase starts
// RQ16: Block erase preprograms selected blocks, self-timed
// RQ17: Block erase done: poll one, toggle steady
// RQ18: Toggle bit inverts each read while busy
// RQ19: Poll bit zero until erase finishes
// RQ20: Address latched on fall, data on rise
// RQ21: Two FFH writes abort pending setup
// RQ22: Outputs float unless chip and output selected; flash model drives the inverse byte instead
// RQ23: Busy device ignores commands except abort; flash model also ignores FFH while erasing
`ifndef FCSM_DEFINES_VH
`define FCSM_DEFINES_VH
`define FCSM_CMD_READ      8'h00
`define FCSM_CMD_ID        8'h90
`define FCSM_CMD_CHIP_ERS  8'h30
`define FCSM_CMD_BLK_ERS   8'h20
`define FCSM_CMD_BLK_CONF  8'hD0
`define FCSM_CMD_RESET     8'hFF
`define FCSM_ID_MFR_ADDR   18'h00000
`define FCSM_ID_DEV_ADDR   18'h00001
`define FCSM_POLL_BIT      7
`define FCSM_TOGGLE_BIT    6
`define FCSM_CLK_MHZ       50
`define FCSM_STEP_NS       100
`define FCSM_STEP_CYC      ((`FCSM_STEP_NS * `FCSM_CLK_MHZ + 999) / 1000)
`define FCSM_BLK_GAP_US    30
`define FCSM_BLK_GAP_CYC   (`FCSM_BLK_GAP_US * `FCSM_CLK_MHZ)
`define FCSM_OP_READ       3'h0
`define FCSM_OP_ID         3'h1
`define FCSM_OP_CHIP_ERS   3'h2
`define FCSM_OP_BLK_ERS    3'h3
`define FCSM_OP_ABORT      3'h4
`define FCSM_OP_CMD        3'h5
`endif

// ---- hw/fcsm_host.v ----
// Host controller that issues command sequences and polls status on a parallel flash bus
`timescale 1ns/1ps
`include "fcsm_defines.vh"
module fcsm_host #(
  parameter AW        = 18,
  parameter STEP_CYC  = `FCSM_STEP_CYC,
  parameter GAP_CYC   = `FCSM_BLK_GAP_CYC
) (
  input  wire          core_clk_i,    // 50 MHz clock
  input  wire          resetn_i,      // Sync reset, active low
  input  wire          req_i,         // Start an operation, pulse
  input  wire [2:0]    op_i,          // Operation code
  input  wire [AW-1:0] addr_i,        // Read/id/block address
  input  wire [7:0]    cmd_i,         // Raw byte for OP_CMD
  input  wire          last_blk_i,    // No further block follows
  output reg           busy_o,        // Operation in progress
  output reg           done_o,        // Completion, pulse
  output reg           refused_o,     // Refused: supply low, pulse
  output reg  [7:0]    rdata_o,       // Read / identifier data
  input  wire          supply_high_i, // Supply at supply_high_level
  output reg  [AW-1:0] fl_addr_o,     // Flash address
  input  wire [7:0]    fl_dq_i,       // Data pins in
  output reg  [7:0]    fl_dq_o,       // Data pins out
  output reg           fl_dq_oe_n_o,  // Data drive enable, low drives
  output reg           fl_ce_n_o,     // Chip select, active low
  output reg           fl_oe_n_o,     // Output enable, active low
  output reg           fl_we_n_o      // Write strobe, active low
);
  localparam S_IDLE = 7'h01;
  localparam S_WR   = 7'h02;
  localparam S_WRH  = 7'h04;
  localparam S_RD   = 7'h08;
  localparam S_RDH  = 7'h10;
  localparam S_GAP  = 7'h20;
  localparam S_DONE = 7'h40;
  localparam CW = 12;
  ////////////////////////////////////////////////////////////////
  reg [7:0]    dq_s1_reg;
  reg [7:0]    dq_s2_reg;
  reg          sup_s1_reg;
  reg          sup_s2_reg;
  always @(posedge core_clk_i) begin
    dq_s1_reg  <= fl_dq_i;
    dq_s2_reg  <= dq_s1_reg;
    sup_s1_reg <= supply_high_i;
    sup_s2_reg <= sup_s1_reg;
  end
  ////////////////////////////////////////////////////////////////
  reg [6:0]    state_reg;
  reg [2:0]    op_reg;
  reg [1:0]    wcnt_reg;    // Writes issued in this sequence
  reg [CW-1:0] cnt_reg;
  reg          poll_reg;    // Status polling rather than data read
  reg          have_prev_reg;
  reg [7:0]    prev_reg;
  reg [AW-1:0] addr_reg;
  reg [7:0]    cmd_reg;
  wire         step_end = (cnt_reg == STEP_CYC - 1);
  // Only the erase and abort sequences are two-write commands
  wire [1:0]   nwr = (op_reg == `FCSM_OP_CHIP_ERS || op_reg == `FCSM_OP_BLK_ERS ||
                      op_reg == `FCSM_OP_ABORT) ? 2'd2 : 2'd1;
  reg  [7:0]   wr_byte;
  always @* begin
    wr_byte = cmd_reg;
    case (op_reg)
      `FCSM_OP_READ:     wr_byte = `FCSM_CMD_READ;                        // RQ4
      `FCSM_OP_ID:       wr_byte = `FCSM_CMD_ID;                          // RQ5
      `FCSM_OP_CHIP_ERS: wr_byte = `FCSM_CMD_CHIP_ERS;                    // RQ7 RQ8
      `FCSM_OP_BLK_ERS:  wr_byte = (wcnt_reg == 2'd0) ? `FCSM_CMD_BLK_ERS
                                                       : `FCSM_CMD_BLK_CONF; // RQ12 RQ13
      `FCSM_OP_ABORT:    wr_byte = `FCSM_CMD_RESET;                       // RQ21
      default:           wr_byte = cmd_reg;                               // RQ3
    endcase
  end
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_reg     <= S_IDLE;
      op_reg        <= `FCSM_OP_READ;
      wcnt_reg      <= 2'd0;
      cnt_reg       <= {CW{1'b0}};
      poll_reg      <= 1'b0;
      have_prev_reg <= 1'b0;
      prev_reg      <= 8'h00;
      addr_reg      <= {AW{1'b0}};
      cmd_reg       <= 8'h00;
      busy_o        <= 1'b0;
      done_o        <= 1'b0;
      refused_o     <= 1'b0;
      rdata_o       <= 8'h00;
      fl_addr_o     <= {AW{1'b0}};
      fl_dq_o       <= 8'h00;
      fl_dq_oe_n_o  <= 1'b1;
      fl_ce_n_o     <= 1'b1;
      fl_oe_n_o     <= 1'b1;
      fl_we_n_o     <= 1'b1;
    end else begin
      done_o    <= 1'b0;
      refused_o <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (req_i) begin
            op_reg        <= op_i;
            addr_reg      <= addr_i;
            cmd_reg       <= cmd_i;
            wcnt_reg      <= 2'd0;
            cnt_reg       <= {CW{1'b0}};
            have_prev_reg <= 1'b0;
            poll_reg      <= 1'b0;
            if (op_i == `FCSM_OP_READ && !sup_s2_reg) begin
              // Supply low: array reads only, no command writes needed
              state_reg <= S_RD;                                   // RQ1 RQ2
              busy_o    <= 1'b1;
              fl_addr_o <= addr_i;
              fl_ce_n_o <= 1'b0;
              fl_oe_n_o <= 1'b0;
            end else if (!sup_s2_reg) begin
              refused_o <= 1'b1;                                   // RQ1 RQ2
            end else begin
              state_reg    <= S_WR;
              busy_o       <= 1'b1;
              fl_ce_n_o    <= 1'b0;
              // Address and select settle one cycle before the strobe falls
              fl_addr_o    <= (op_i == `FCSM_OP_ID) ? {AW{1'b0}} : addr_i; // RQ20
            end
          end
        end
        S_WR: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == {CW{1'b0}}) begin
            // Data drive starts with the falling strobe so no write sees a floating bus
            fl_dq_o      <= wr_byte;
            fl_dq_oe_n_o <= 1'b0;
            fl_we_n_o    <= 1'b0;                                  // RQ14 RQ20
          end
          if (cnt_reg == STEP_CYC) begin
            // Data captured on the rising strobe; keep it driven one step more
            cnt_reg   <= {CW{1'b0}};
            fl_we_n_o <= 1'b1;                                     // RQ8 RQ20
            state_reg <= S_WRH;
            wcnt_reg  <= wcnt_reg + 1'b1;
          end
        end
        S_WRH: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (step_end) begin
            cnt_reg      <= {CW{1'b0}};
            fl_dq_oe_n_o <= 1'b1;
            if (wcnt_reg < nwr) begin
              // Second write: its falling edge latches the block address
              fl_addr_o <= addr_reg;                               // RQ14
              state_reg <= S_WR;
            end else if (op_reg == `FCSM_OP_BLK_ERS && !last_blk_i) begin
              fl_ce_n_o <= 1'b1;
              state_reg <= S_GAP;                                  // RQ15
            end else if (op_reg == `FCSM_OP_READ || op_reg == `FCSM_OP_ID) begin
              fl_addr_o <= addr_reg;                               // RQ5
              fl_oe_n_o <= 1'b0;
              state_reg <= S_RD;
            end else if (op_reg == `FCSM_OP_CHIP_ERS || op_reg == `FCSM_OP_BLK_ERS) begin
              // Device self-times the erase; host only polls
              poll_reg  <= 1'b1;                                   // RQ9 RQ10 RQ16 RQ23
              fl_oe_n_o <= 1'b0;
              state_reg <= S_RD;
            end else begin
              fl_ce_n_o <= 1'b1;
              state_reg <= S_DONE;
            end
          end
        end
        S_GAP: begin
          // Loading window stays open only while the next load arrives in time
          if (!last_blk_i && req_i && cnt_reg < GAP_CYC - STEP_CYC) begin
            addr_reg  <= addr_i;
            fl_addr_o <= addr_i;
            wcnt_reg  <= 2'd1;
            cnt_reg   <= {CW{1'b0}};
            fl_ce_n_o <= 1'b0;
            state_reg <= S_WR;                                     // RQ15
          end else if (last_blk_i || cnt_reg >= GAP_CYC) begin
            cnt_reg   <= {CW{1'b0}};
            poll_reg  <= 1'b1;
            fl_ce_n_o <= 1'b0;
            fl_oe_n_o <= 1'b0;
            state_reg <= S_RD;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        S_RD: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == STEP_CYC + 1) begin
            // Two extra cycles cover the input synchroniser
            cnt_reg   <= {CW{1'b0}};
            fl_oe_n_o <= 1'b1;                                     // RQ22
            state_reg <= S_RDH;
            rdata_o   <= dq_s2_reg;
            prev_reg  <= dq_s2_reg;
            have_prev_reg <= 1'b1;
            if (!poll_reg) begin
              fl_ce_n_o <= 1'b1;
              state_reg <= S_DONE;
            end else if (have_prev_reg && dq_s2_reg[`FCSM_POLL_BIT] &&
                         dq_s2_reg[`FCSM_TOGGLE_BIT] == prev_reg[`FCSM_TOGGLE_BIT]) begin
              fl_ce_n_o <= 1'b1;                                   // RQ11 RQ17 RQ18 RQ19
              state_reg <= S_DONE;
            end
          end
        end
        S_RDH: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (step_end) begin
            cnt_reg   <= {CW{1'b0}};
            fl_oe_n_o <= 1'b0;
            state_reg <= S_RD;
          end
        end
        S_DONE: begin
          busy_o    <= 1'b0;
          done_o    <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- verif/fcsm_flash_model.sv ----
// Behavioural flash device with command register and erase status
`timescale 1ns/1ps
module fcsm_flash_model #(
  parameter [7:0] MFR    = 8'h5A, // Arbitrary value
  parameter [7:0] DEV    = 8'h3C, // Arbitrary value
  parameter       GAP_NS = 600,
  parameter       ERS_NS = 3000
) (
  input  wire        supply_high_i, // Supply level
  input  wire        id_high_voltage_line_i, // Identifier line raised
  input  wire [17:0] a_i,           // Address
  input  wire [7:0]  d_i,           // Data from host
  input  wire        ce_n_i,        // Chip select
  input  wire        oe_n_i,        // Output enable
  input  wire        we_n_i,        // Write strobe
  output reg  [7:0]  q_o            // Data to host
);
  reg  [7:0]  cmd = 8'h00;
  reg  [2:0]  stage = 3'h0;
  reg         ff = 1'b0;
  reg         tog = 1'b0;
  reg         erased = 1'b0;
  reg  [7:0]  rd;
  reg  [17:0] ea;
  integer     nblk = 0;
  time        t_rise, t_end;
  always @(negedge supply_high_i) begin cmd = 8'h00; stage = 3'h0; end
  always @(negedge we_n_i) if (!ce_n_i && (stage == 3'h2 || stage == 3'h3)) ea = a_i;
  always @(posedge we_n_i) if (!ce_n_i && supply_high_i && stage != 3'h4) begin
    if (d_i == 8'hFF) begin
      if (ff) begin cmd = 8'h00; stage = 3'h0; end
      ff = ~ff;
    end else begin
      ff = 1'b0;
      if (stage == 3'h1 && d_i == 8'h30) begin stage = 3'h4; t_end = $time + ERS_NS; end
      else if (stage >= 3'h2 && d_i == 8'hD0) begin
        stage = 3'h3; t_rise = $time; nblk = nblk + 1; end
      else if (d_i == 8'h30) stage = 3'h1;
      else if (d_i == 8'h20) stage = 3'h2;
      else begin cmd = d_i; stage = 3'h0; end
    end
  end
  always #50 begin
    if (stage == 3'h3 && we_n_i && $time - t_rise > GAP_NS) begin
      stage = 3'h4; t_end = $time + ERS_NS; end
    if (stage == 3'h4 && $time >= t_end) begin
      stage = 3'h0; cmd = 8'h00; erased = 1'b1; end
  end
  always @(negedge oe_n_i) if (!ce_n_i && stage >= 3'h3) tog = ~tog;
  always @* begin
    if (stage >= 3'h3) rd = {1'b0, tog, 6'h00};
    else if (!supply_high_i && id_high_voltage_line_i) rd = a_i[0] ? DEV : MFR;
    else if (cmd == 8'h90) rd = (a_i == 18'h0) ? MFR : (a_i == 18'h1) ? DEV : 8'h00;
    else if (erased) rd = 8'hFF;
    else rd = a_i[7:0] ^ 8'hA5;
    // Released bus shows the inverse so a stale byte cannot pass
    q_o = (!ce_n_i && !oe_n_i) ? rd : ~rd;
  end
endmodule

// ---- verif/fcsm_host_monitor.sv ----
// Concurrent checks on the flash host controller pins
`timescale 1ns/1ps
module fcsm_host_monitor (
  input wire       core_clk_i,    // Clock
  input wire       resetn_i,      // Sync reset, active low
  input wire       supply_high_i, // Supply level
  input wire [7:0] fl_dq_o,       // Data out
  input wire       fl_dq_oe_n_o,  // Data drive, low drives
  input wire       fl_ce_n_o,     // Chip select
  input wire       fl_oe_n_o,     // Output enable
  input wire       fl_we_n_o,     // Write strobe
  input wire       done_o,        // Completion pulse
  input wire       refused_o      // Refusal pulse
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_we_low;
    (!fl_we_n_o)[*5];
  endsequence
  a_strobe_excl: assert property (!fl_oe_n_o |-> fl_we_n_o)
    else $error("read and write strobes low together");
  a_ce_with_strobe: assert property ((!fl_we_n_o || !fl_oe_n_o) |-> !fl_ce_n_o)
    else $error("strobe without chip select");
  a_drive_on_write: assert property (!fl_we_n_o |-> !fl_dq_oe_n_o)
    else $error("write strobe without data drive");
  a_no_drive_read: assert property (!fl_oe_n_o |-> fl_dq_oe_n_o)
    else $error("data driven during read");
  a_we_width: assert property ($fell(fl_we_n_o) |-> s_we_low)
    else $error("write strobe too short");
  a_data_hold: assert property ($rose(fl_we_n_o) |-> $stable(fl_dq_o) && !fl_dq_oe_n_o)
    else $error("data not held at strobe rise");
  a_low_no_write: assert property (!supply_high_i [*3] |-> fl_we_n_o)
    else $error("write while supply low");
  a_refuse_pulse: assert property (refused_o |=> !refused_o)
    else $error("refusal longer than one cycle");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("completion longer than one cycle");
endmodule
bind fcsm_host fcsm_host_monitor u_mon (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .supply_high_i(supply_high_i),
  .fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(fl_dq_oe_n_o), .fl_ce_n_o(fl_ce_n_o),
  .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o), .done_o(done_o), .refused_o(refused_o));

// ---- verif/tb_fcsm_host.sv ----
// Self-checking testbench of the flash host controller
`timescale 1ns/1ps
module tb_fcsm_host;
  localparam [7:0] MFR = 8'h5A; // Arbitrary value
  localparam [7:0] DEV = 8'h3C; // Arbitrary value
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         req = 1'b0;
  reg  [2:0]  op = 3'h0;
  reg  [17:0] addr = 18'h00000;
  reg  [7:0]  cmd = 8'h00;
  reg         last = 1'b1;
  reg         sup = 1'b1;
  reg         id_high_voltage_line = 1'b0;
  reg  [1:0]  res;
  wire        busy, done, refused, dq_oe_n, ce_n, oe_n, we_n;
  wire [7:0]  rdata, dq_o, fq, dq_i;
  wire [17:0] fa;
  integer     num_errors = 0;
  integer     n_tests = 0;
  integer     k;
  assign dq_i = dq_oe_n ? fq : dq_o;
  fcsm_host #(.GAP_CYC(40)) uut (.core_clk_i(clk), .resetn_i(rst_n), .req_i(req), .op_i(op),
    .addr_i(addr), .cmd_i(cmd), .last_blk_i(last), .busy_o(busy), .done_o(done),
    .refused_o(refused), .rdata_o(rdata), .supply_high_i(sup), .fl_addr_o(fa), .fl_dq_i(dq_i),
    .fl_dq_o(dq_o), .fl_dq_oe_n_o(dq_oe_n), .fl_ce_n_o(ce_n), .fl_oe_n_o(oe_n), .fl_we_n_o(we_n));
  fcsm_flash_model #(.MFR(MFR), .DEV(DEV)) u_flash (.supply_high_i(sup), .a_i(fa), .d_i(dq_o),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .q_o(fq),
    .id_high_voltage_line_i(id_high_voltage_line));
  initial forever #10 clk = ~clk;
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task start(input [2:0] o, input [17:0] a, input [7:0] c);
    begin
      @(posedge clk); #1; op = o; addr = a; cmd = c; req = 1'b1;
      @(posedge clk); #1; req = 1'b0;
    end
  endtask
  task run(input [2:0] o, input [17:0] a, input [7:0] c);
    begin
      start(o, a, c);
      res = 2'b00;
      for (k = 0; k < 3000 && res == 2'b00; k = k + 1) begin
        if (done === 1'b1) res = 2'b01;
        if (refused === 1'b1) res = 2'b10;
        if (res == 2'b00) @(posedge clk);
        #1;
      end
      if (res == 2'b00) begin
        num_errors = num_errors + 1;
        $display("Error %0t: operation timed out", $time);
      end
    end
  endtask
  task t_low;
    begin
      sup = 1'b0; repeat (4) @(posedge clk);
      run(3'h0, 18'h00005, 8'h00); chk({6'h0, res}, 8'h01); chk(rdata, 8'hA0);
      id_high_voltage_line = 1'b1;
      run(3'h0, 18'h00001, 8'h00); chk(rdata, DEV);
      run(3'h0, 18'h00000, 8'h00); chk(rdata, MFR);
      id_high_voltage_line = 1'b0;
      run(3'h2, 18'h00000, 8'h00); chk({6'h0, res}, 8'h02);
      sup = 1'b1; repeat (4) @(posedge clk);
    end
  endtask
  task t_abort;
    begin
      run(3'h5, 18'h0, 8'h30); run(3'h4, 18'h0, 8'h00);
      run(3'h0, 18'h00007, 8'h00); chk(rdata, 8'hA2);
    end
  endtask
  task t_blk;
    begin
      last = 1'b0; start(3'h3, 18'h04000, 8'h00);
      for (k = 0; k < 100 && ce_n !== 1'b1; k = k + 1) begin
        @(posedge clk); #1;
      end
      chk({7'h00, ce_n}, 8'h01);
      chk(u_flash.ea[15:8], 8'h40);
      // Second load arrives inside the window; the window then expires on its own
      run(3'h3, 18'h08000, 8'h00); chk({6'h0, res}, 8'h01); chk(rdata, 8'hFF);
      chk(u_flash.nblk[7:0], 8'h02); chk(u_flash.ea[15:8], 8'h80);
      last = 1'b1;
      run(3'h3, 18'h0C000, 8'h00); chk({6'h0, res}, 8'h01); chk(rdata, 8'hFF);
      chk(u_flash.nblk[7:0], 8'h03); chk(u_flash.ea[15:8], 8'hC0);
    end
  endtask
  task complete_run;
    begin
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #400000; num_errors = num_errors + 1; complete_run;
  end
  initial begin
    repeat (20) @(posedge clk); #1; rst_n = 1'b1; repeat (3) @(posedge clk);
    chk({busy, done, ce_n, oe_n, we_n, dq_oe_n}, 8'h0F);
    t_low;
    run(3'h1, 18'h0, 8'h00); chk(rdata, MFR);
    run(3'h1, 18'h1, 8'h00); chk(rdata, DEV);
    t_abort;
    t_blk;
    run(3'h2, 18'h0, 8'h00); chk({6'h0, res}, 8'h01); chk(rdata, 8'hFF);
    run(3'h0, 18'h00009, 8'h00); chk(rdata, 8'hFF);
    complete_run;
  end
endmodule
